// *** verilog/psd_pkg.sv ***
/*
  Constants, types and register map of the module power-down sequencer.
  Assumes one 100 MHz clock and an APB slave port with 32-bit data.
*/
// Operation
// - Software power-down applies while hardware request asserted
// - Deinit bits set on all masked lanes deactivate the path; an empty lane mask never does
// - Tx turn-off advances to initialized by itself
// - Initialized with re-deinit true goes to deinit
// - Deinit disables tx, releases resources, then deactivated
// - Entering deactivated sets the path changed flag
// - Reading the flags deasserts the interrupt
// - Low-power allow bit moves ready to powering-down
// - Powering-down drops consumption before low power
// - Entering low power sets module changed flag
// - Apply ignored while configuration is in progress
// - Apply trigger clears on command completion
// - Default mode ignores apply in transient states
// - Stepped-only bit sits at byte two bit six
// - Stepped-only mode: pending init only stores provisioning
// - Stepped-only mode: no apply-immediate support
`default_nettype none

package psd_pkg;

  localparam int CLK_NS = 10;
  localparam int TMR_W = 16;

  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int TURNOFF_NS = 2000;
  localparam int TURNON_NS = 2000;
  localparam int PATH_INIT_NS = 2000;
  localparam int DEINIT_NS = 2000;
  localparam int PWRDN_NS = 5000;
  localparam int PWRUP_NS = 5000;
  localparam int CFG_NS = 1000;
  localparam logic [TMR_W-1:0] TURNOFF_CYC = TMR_W'(ns_to_cyc(TURNOFF_NS));
  localparam logic [TMR_W-1:0] TURNON_CYC = TMR_W'(ns_to_cyc(TURNON_NS));
  localparam logic [TMR_W-1:0] PATH_INIT_CYC = TMR_W'(ns_to_cyc(PATH_INIT_NS));
  localparam logic [TMR_W-1:0] DEINIT_CYC = TMR_W'(ns_to_cyc(DEINIT_NS));
  localparam logic [TMR_W-1:0] PWRDN_CYC = TMR_W'(ns_to_cyc(PWRDN_NS));
  localparam logic [TMR_W-1:0] PWRUP_CYC = TMR_W'(ns_to_cyc(PWRUP_NS));
  localparam logic [TMR_W-1:0] CFG_CYC = TMR_W'(ns_to_cyc(CFG_NS));
  localparam logic [TMR_W-1:0] TMR_ONE = TMR_W'(1);

  localparam int AW = 12;
  localparam logic [AW-1:0] OFF_ADVERT = 12'h000;
  localparam logic [AW-1:0] OFF_CTRL = 12'h004;
  localparam logic [AW-1:0] OFF_DEINIT = 12'h008;
  localparam logic [AW-1:0] OFF_LANE_MASK = 12'h00c;
  localparam logic [AW-1:0] OFF_STATE = 12'h010;
  localparam logic [AW-1:0] OFF_FLAGS = 12'h014;
  localparam logic [AW-1:0] OFF_FLAG_CLR = 12'h018;
  localparam logic [AW-1:0] OFF_FLAG_EN = 12'h01c;
  localparam logic [AW-1:0] OFF_CFG = 12'h020;
  localparam logic [AW-1:0] OFF_STAGED = 12'h024;
  localparam logic [AW-1:0] OFF_ACTIVE = 12'h028;

  localparam int STEPPED_BIT = 22;
  localparam int CTRL_ALLOW_BIT = 0;
  localparam int CFG_APPLY_BIT = 0;
  localparam int CFG_IMM_BIT = 1;
  localparam int CFG_PEND_BIT = 2;
  localparam int CFG_STAT_LSB = 4;
  localparam int STATE_MOD_LSB = 4;
  localparam int STATE_HWREQ_BIT = 8;
  localparam int FLAG_PATH_BIT = 0;
  localparam int FLAG_MOD_BIT = 1;
  localparam int NFLAG = 2;
  localparam int CFG_W = 8;

  localparam logic [3:0] CFG_UNDEF = 4'h0;
  localparam logic [3:0] CFG_SUCCESS = 4'h1;
  localparam logic [3:0] CFG_IN_PROGRESS = 4'h8;
  localparam logic [NFLAG-1:0] FLAG_EN_RST = 2'h3;
  localparam logic [CFG_W-1:0] CFG_RST = 8'h00;

  typedef enum logic [2:0] {
    PATH_DEACTIVATED,
    PATH_INIT,
    PATH_INITIALIZED,
    PATH_TX_TURNON,
    PATH_ACTIVATED,
    PATH_TX_TURNOFF,
    PATH_DEINIT
  } psd_path_state_t;

  typedef enum logic [1:0] {
    MOD_LOW_POWER,
    MOD_POWERING_UP,
    MOD_READY,
    MOD_POWERING_DOWN
  } psd_mod_state_t;

  typedef struct packed {
    logic tx_enable;
    logic resources_on;
    logic high_power;
  } psd_power_out_t;

endpackage

`default_nettype wire

// *** verilog/psd_sequencer.sv ***
/*
  Module power-down sequencer: APB register file, one data path state
  machine, module power state machine, state-changed flags and interrupt.
  Assumes a host on APB, the hardware low-power request from a pin, and
  a downstream power stage that follows the power_out levels.
*/
`timescale 1ns/10ps
`default_nettype none

module psd_sequencer #(
  parameter int N_LANES = 8,
  parameter bit STEPPED_CONFIG_ONLY = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [psd_pkg::AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hw_low_power_request,
  output logic intr,
  output psd_pkg::psd_power_out_t power_out
);
  import psd_pkg::*;

  // lane bits live in one 32-bit register word, so wider paths cannot be served
  if (N_LANES < 1 || N_LANES > 32)
  begin
    $error("N_LANES must lie in 1..32");
  end

  function automatic logic addr_mapped(input logic [AW-1:0] a);
    return (a == OFF_ADVERT) || (a == OFF_CTRL) || (a == OFF_DEINIT) ||
           (a == OFF_LANE_MASK) || (a == OFF_STATE) || (a == OFF_FLAGS) ||
           (a == OFF_FLAG_CLR) || (a == OFF_FLAG_EN) || (a == OFF_CFG) ||
           (a == OFF_STAGED) || (a == OFF_ACTIVE);
  endfunction

  function automatic logic timer_done(input logic [TMR_W-1:0] t);
    return t <= TMR_ONE;
  endfunction

  logic hw_req_meta;
  logic hw_req_sync;
  logic sw_allow;
  logic next_sw_allow;
  logic [N_LANES-1:0] deinit_bits;
  logic [N_LANES-1:0] next_deinit_bits;
  logic [N_LANES-1:0] lane_mask;
  logic [N_LANES-1:0] next_lane_mask;
  logic [NFLAG-1:0] flags;
  logic [NFLAG-1:0] next_flags;
  logic [NFLAG-1:0] flag_en;
  logic [NFLAG-1:0] next_flag_en;
  logic [CFG_W-1:0] staged_cfg;
  logic [CFG_W-1:0] next_staged_cfg;
  logic [CFG_W-1:0] active_cfg;
  logic [CFG_W-1:0] next_active_cfg;
  logic apply_trig;
  logic next_apply_trig;
  logic path_init_pending;
  logic next_path_init_pending;
  logic [3:0] cfg_status;
  logic [3:0] next_cfg_status;
  logic [TMR_W-1:0] cfg_cnt;
  logic [TMR_W-1:0] next_cfg_cnt;
  psd_path_state_t path_state;
  psd_path_state_t next_path_state;
  logic [TMR_W-1:0] path_cnt;
  logic [TMR_W-1:0] next_path_cnt;
  psd_mod_state_t mod_state;
  psd_mod_state_t next_mod_state;
  logic [TMR_W-1:0] mod_cnt;
  logic [TMR_W-1:0] next_mod_cnt;
  logic [31:0] next_prdata;
  logic next_intr;
  psd_power_out_t next_power_out;

  logic wr;
  logic rd;
  logic setup_rd;
  logic deact;
  logic lp_req;
  logic transient;
  logic pend_go;
  logic pend_consume;
  logic set_path_flag;
  logic set_mod_flag;
  logic [NFLAG-1:0] rd_clr;
  logic [NFLAG-1:0] wr_clr;

  // zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_mapped(paddr);
  assign wr = psel && penable && pwrite && addr_mapped(paddr);
  assign rd = psel && penable && !pwrite && addr_mapped(paddr);
  assign setup_rd = psel && !penable && !pwrite;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hw_req_meta <= 1'b0;
      hw_req_sync <= 1'b0;
    end
    else
    begin
      hw_req_meta <= hw_low_power_request;
      hw_req_sync <= hw_req_meta;
    end
  end

  // the allow bit only counts while the pin asks for software control
  assign lp_req = hw_req_sync && sw_allow;
  assign deact = ((lane_mask != '0) && ((deinit_bits & lane_mask) == lane_mask)) ||
                 (mod_state != MOD_READY);
  assign transient = (path_state == PATH_TX_TURNOFF) || (path_state == PATH_DEINIT) ||
                     (path_state == PATH_INIT) || (path_state == PATH_TX_TURNON);
  assign pend_go = path_init_pending && !STEPPED_CONFIG_ONLY;

  // plain control registers
  always_comb
  begin
    next_sw_allow = sw_allow;
    next_deinit_bits = deinit_bits;
    next_lane_mask = lane_mask;
    next_flag_en = flag_en;
    next_staged_cfg = staged_cfg;
    wr_clr = '0;
    if (wr)
    begin
      case (paddr)
        OFF_CTRL: next_sw_allow = pwdata[CTRL_ALLOW_BIT];
        OFF_DEINIT: next_deinit_bits = pwdata[N_LANES-1:0];
        OFF_LANE_MASK: next_lane_mask = pwdata[N_LANES-1:0];
        OFF_FLAG_EN: next_flag_en = pwdata[NFLAG-1:0];
        OFF_FLAG_CLR: wr_clr = pwdata[NFLAG-1:0];
        OFF_STAGED: next_staged_cfg = pwdata[CFG_W-1:0];
        default: next_sw_allow = sw_allow;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sw_allow <= 1'b0;
      deinit_bits <= '0;
      lane_mask <= '1;
      flag_en <= FLAG_EN_RST;
      staged_cfg <= CFG_RST;
    end
    else
    begin
      sw_allow <= next_sw_allow;
      deinit_bits <= next_deinit_bits;
      lane_mask <= next_lane_mask;
      flag_en <= next_flag_en;
      staged_cfg <= next_staged_cfg;
    end
  end

  // apply handling
  always_comb
  begin
    next_apply_trig = apply_trig;
    next_path_init_pending = path_init_pending;
    next_cfg_status = cfg_status;
    next_cfg_cnt = cfg_cnt;
    next_active_cfg = active_cfg;
    if (cfg_status == CFG_IN_PROGRESS)
    begin
      if (timer_done(cfg_cnt))
      begin
        next_active_cfg = staged_cfg;
        next_apply_trig = 1'b0;
        next_path_init_pending = 1'b1;
        next_cfg_status = CFG_SUCCESS;
      end
      else
      begin
        next_cfg_cnt = cfg_cnt - TMR_ONE;
      end
    end
    if (pend_consume)
    begin
      next_path_init_pending = 1'b0;
    end
    if (wr && paddr == OFF_CFG)
    begin
      if (pwdata[CFG_PEND_BIT])
      begin
        next_path_init_pending = 1'b0;
      end
      // apply writes during a running command, or in a transient path state outside stepped-only mode, are dropped
      if (pwdata[CFG_APPLY_BIT] && cfg_status != CFG_IN_PROGRESS &&
          (STEPPED_CONFIG_ONLY || !transient))
      begin
        next_apply_trig = 1'b1;
        next_cfg_status = CFG_IN_PROGRESS;
        next_cfg_cnt = CFG_CYC;
      end
      else if (pwdata[CFG_IMM_BIT] && !STEPPED_CONFIG_ONLY &&
               cfg_status != CFG_IN_PROGRESS && !transient)
      begin
        next_active_cfg = staged_cfg;
        next_cfg_status = CFG_SUCCESS;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      apply_trig <= 1'b0;
      path_init_pending <= 1'b0;
      cfg_status <= CFG_UNDEF;
      cfg_cnt <= '0;
      active_cfg <= CFG_RST;
    end
    else
    begin
      apply_trig <= next_apply_trig;
      path_init_pending <= next_path_init_pending;
      cfg_status <= next_cfg_status;
      cfg_cnt <= next_cfg_cnt;
      active_cfg <= next_active_cfg;
    end
  end

  // data path state machine
  always_comb
  begin
    next_path_state = path_state;
    next_path_cnt = path_cnt;
    set_path_flag = 1'b0;
    pend_consume = 1'b0;
    if (!timer_done(path_cnt))
    begin
      next_path_cnt = path_cnt - TMR_ONE;
    end
    case (path_state)
      PATH_ACTIVATED:
        if (deact || pend_go)
        begin
          next_path_state = PATH_TX_TURNOFF;
          next_path_cnt = TURNOFF_CYC;
        end
      PATH_TX_TURNOFF:
        if (timer_done(path_cnt))
        begin
          next_path_state = PATH_INITIALIZED;
        end
      PATH_INITIALIZED:
        if (deact)
        begin
          next_path_state = PATH_DEINIT;
          next_path_cnt = DEINIT_CYC;
        end
        else if (pend_go)
        begin
          pend_consume = 1'b1;
          next_path_state = PATH_INIT;
          next_path_cnt = PATH_INIT_CYC;
        end
        else
        begin
          next_path_state = PATH_TX_TURNON;
          next_path_cnt = TURNON_CYC;
        end
      PATH_DEINIT:
        if (timer_done(path_cnt))
        begin
          next_path_state = PATH_DEACTIVATED;
          set_path_flag = 1'b1;
        end
      PATH_DEACTIVATED:
        // deact holds while the module is not ready, so high power comes first
        if (!deact)
        begin
          pend_consume = pend_go;
          next_path_state = PATH_INIT;
          next_path_cnt = PATH_INIT_CYC;
        end
      PATH_INIT:
        if (timer_done(path_cnt))
        begin
          next_path_state = PATH_INITIALIZED;
        end
      PATH_TX_TURNON:
        if (timer_done(path_cnt))
        begin
          next_path_state = PATH_ACTIVATED;
          set_path_flag = 1'b1;
        end
      default:
        next_path_state = PATH_DEACTIVATED;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      path_state <= PATH_DEACTIVATED;
      path_cnt <= '0;
    end
    else
    begin
      path_state <= next_path_state;
      path_cnt <= next_path_cnt;
    end
  end

  // module power state machine
  always_comb
  begin
    next_mod_state = mod_state;
    next_mod_cnt = mod_cnt;
    set_mod_flag = 1'b0;
    if (!timer_done(mod_cnt))
    begin
      next_mod_cnt = mod_cnt - TMR_ONE;
    end
    case (mod_state)
      MOD_LOW_POWER:
        if (!lp_req)
        begin
          next_mod_state = MOD_POWERING_UP;
          next_mod_cnt = PWRUP_CYC;
        end
      MOD_POWERING_UP:
        if (timer_done(mod_cnt))
        begin
          next_mod_state = MOD_READY;
          set_mod_flag = 1'b1;
        end
      MOD_READY:
        if (lp_req && path_state == PATH_DEACTIVATED)
        begin
          next_mod_state = MOD_POWERING_DOWN;
          next_mod_cnt = PWRDN_CYC;
        end
      MOD_POWERING_DOWN:
        if (timer_done(mod_cnt))
        begin
          next_mod_state = MOD_LOW_POWER;
          set_mod_flag = 1'b1;
        end
      default:
        next_mod_state = MOD_LOW_POWER;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mod_state <= MOD_LOW_POWER;
      mod_cnt <= '0;
    end
    else
    begin
      mod_state <= next_mod_state;
      mod_cnt <= next_mod_cnt;
    end
  end

  // power levels follow the next state so they change on state entry
  always_comb
  begin
    next_power_out.tx_enable = (next_path_state == PATH_ACTIVATED) ||
                               (next_path_state == PATH_TX_TURNON);
    next_power_out.resources_on = (next_path_state != PATH_DEACTIVATED) &&
                                  (next_path_state != PATH_DEINIT);
    next_power_out.high_power = (next_mod_state == MOD_READY) ||
                                (next_mod_state == MOD_POWERING_UP);
  end

  // flags: a read clears only the bits it returned, a write to OFF_FLAG_CLR clears the bits written as 1, set wins
  assign rd_clr = (rd && paddr == OFF_FLAGS) ? prdata[NFLAG-1:0] : '0;

  always_comb
  begin
    next_flags = flags & ~rd_clr & ~wr_clr;
    next_flags[FLAG_PATH_BIT] = next_flags[FLAG_PATH_BIT] | set_path_flag;
    next_flags[FLAG_MOD_BIT] = next_flags[FLAG_MOD_BIT] | set_mod_flag;
    next_intr = |(next_flags & flag_en);
  end

  // read data is captured in the setup cycle and held through the access
  always_comb
  begin
    next_prdata = '0;
    case (paddr)
      OFF_ADVERT: next_prdata[STEPPED_BIT] = STEPPED_CONFIG_ONLY;
      OFF_CTRL: next_prdata[CTRL_ALLOW_BIT] = sw_allow;
      OFF_DEINIT: next_prdata[N_LANES-1:0] = deinit_bits;
      OFF_LANE_MASK: next_prdata[N_LANES-1:0] = lane_mask;
      OFF_STATE:
      begin
        next_prdata[2:0] = path_state;
        next_prdata[STATE_MOD_LSB+:2] = mod_state;
        next_prdata[STATE_HWREQ_BIT] = hw_req_sync;
      end
      OFF_FLAGS: next_prdata[NFLAG-1:0] = flags;
      OFF_FLAG_EN: next_prdata[NFLAG-1:0] = flag_en;
      OFF_CFG:
      begin
        next_prdata[CFG_APPLY_BIT] = apply_trig;
        next_prdata[CFG_PEND_BIT] = path_init_pending;
        next_prdata[CFG_STAT_LSB+:4] = cfg_status;
      end
      OFF_STAGED: next_prdata[CFG_W-1:0] = staged_cfg;
      OFF_ACTIVE: next_prdata[CFG_W-1:0] = active_cfg;
      default: next_prdata = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flags <= '0;
      intr <= 1'b0;
      prdata <= '0;
      power_out <= '0;
    end
    else
    begin
      flags <= next_flags;
      intr <= next_intr;
      power_out <= next_power_out;
      if (setup_rd)
      begin
        prdata <= next_prdata;
      end
    end
  end

endmodule

`default_nettype wire

// *** test/psd_sequencer_assertions.sv ***
/*
  Port checker for psd_sequencer, bound into every instance below.
  Assumes the psd_pkg register offsets and the single pclk domain.
*/
`timescale 1ns/10ps
`default_nettype none

module psd_sequencer_assertions #(
  parameter int N_LANES = 8,
  parameter bit STEPPED_CONFIG_ONLY = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [psd_pkg::AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic hw_low_power_request,
  input wire logic intr,
  input wire psd_pkg::psd_power_out_t power_out
);
  import psd_pkg::*;
  wire logic access = psel && penable;
  wire logic rd_setup = psel && !penable && !pwrite;
  wire logic flag_access = access && (paddr == OFF_FLAGS || paddr == OFF_FLAG_CLR || paddr == OFF_FLAG_EN);

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_zero_wait: assert property (access |-> pready)
    else $error("apb access without ready");
  a_err_mapped: assert property (access && paddr[1:0] == 2'b00 |-> pslverr == (paddr > OFF_ACTIVE))
    else $error("error response does not match the address map");
  a_unmapped_zero: assert property (rd_setup && paddr > OFF_ACTIVE |=> prdata == 32'h0000_0000)
    else $error("unmapped read returned data");
  a_advert_word: assert property (rd_setup && paddr == OFF_ADVERT |=> prdata == (32'(STEPPED_CONFIG_ONLY) << STEPPED_BIT))
    else $error("advertisement word wrong");
  a_flags_width: assert property (rd_setup && paddr == OFF_FLAGS |=> prdata[31:2] == 30'h0)
    else $error("flag word has bits above the flags");
  a_cfg_no_err: assert property (access && pwrite && paddr == OFF_CFG |-> !pslverr)
    else $error("refused apply gave an error response");
  // flags clear at the access edge; an enable write takes one more cycle to reach intr
  a_intr_fall_read: assert property ($fell(intr) |-> $past(flag_access) || $past(flag_access, 2))
    else $error("interrupt fell without a flag access");
  a_tx_needs_res: assert property (power_out.tx_enable |-> power_out.resources_on)
    else $error("transmit enabled without path resources");
  a_res_needs_hp: assert property (power_out.resources_on |-> power_out.high_power)
    else $error("path resources on in low power");
  a_hp_drop_req: assert property ($fell(power_out.high_power) |-> $past(hw_low_power_request, 3))
    else $error("power dropped without the hardware request");

  cover property ($rose(intr));
  cover property ($fell(power_out.high_power));
  cover property (access && pslverr);
endmodule

bind psd_sequencer psd_sequencer_assertions #(
  .N_LANES(N_LANES),
  .STEPPED_CONFIG_ONLY(STEPPED_CONFIG_ONLY)
) i_chk (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .hw_low_power_request(hw_low_power_request),
  .intr(intr),
  .power_out(power_out)
);

`default_nettype wire

// *** test/psd_host_pins.sv ***
/*
  Host-side pin model: drives the hardware low-power request and counts interrupts.
  Assumes the same pclk and presetn as the sequencer.
*/
`timescale 1ns/10ps
`default_nettype none

module psd_host_pins (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic intr,
  input wire logic request_level,
  output logic hw_low_power_request,
  output int intr_rises
);
  logic intr_d;

  // pin asserted hands power-down to the register bits; the bench drops it to test that
  assign hw_low_power_request = request_level;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      intr_d <= 1'b0;
      intr_rises <= 0;
    end
    else
    begin
      intr_d <= intr;
      if (intr && !intr_d)
        intr_rises <= intr_rises + 1;
    end
  end
endmodule

`default_nettype wire

// *** test/module_power_down_sequencer_tb.sv ***
/*
  Self-checking bench for psd_sequencer: APB host tasks and a state model.
  Assumes psd_host_pins as far-side pin model and the bound port checker.
*/
`timescale 1ns/10ps
`default_nettype none

module module_power_down_sequencer_tb;
  import psd_pkg::*;
  localparam bit STEP = 1'b0;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic hw_low_power_request;
  logic lp_pin = 1'b1;
  logic intr;
  psd_power_out_t power_out;
  int intr_rises;
  int failures = 0;
  int checked = 0;
  logic [31:0] rdata;
  logic rerr;
  int exp_flags = 0;
  int path_q[$];
  logic [7:0] stg;
  int base;

  always #5 pclk = ~pclk;

  psd_sequencer #(.N_LANES(8), .STEPPED_CONFIG_ONLY(STEP)) i_dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .hw_low_power_request(hw_low_power_request),
    .intr(intr),
    .power_out(power_out)
  );

  psd_host_pins i_host (
    .pclk(pclk),
    .presetn(presetn),
    .intr(intr),
    .request_level(lp_pin),
    .hw_low_power_request(hw_low_power_request),
    .intr_rises(intr_rises)
  );

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one transfer; pready is waited for, never assumed
  task automatic apb(input logic wr, input logic [AW-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16)
    begin
      failures++;
      $display("wrong value pready expected 1 seen %b", pready);
      end_of_test();
    end
  endtask

  task automatic wait_state(input int ps, input int ms);
    int i;
    for (i = 0; i < 2000; i++)
    begin
      apb(1'b0, OFF_STATE, 32'h0);
      if (rdata[2:0] === ps[2:0] && rdata[5:4] === ms[1:0])
        break;
    end
    checked++;
    if (i == 2000)
    begin
      failures++;
      $display("wrong value state expected %0d %0d seen %h", ps, ms, rdata);
      end_of_test();
    end
  endtask

  task automatic read_flags();
    check("intr before read", 1, intr);
    apb(1'b0, OFF_FLAGS, 32'h0);
    check("flags", exp_flags, rdata);
    exp_flags = 0;
    repeat (3) @(posedge pclk);
    check("intr after read", 0, intr);
  endtask

  initial
  begin
    void'($urandom(32'h8edd_9ed4));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    wait_state(4, 2);
    check("power", 3'b111, power_out);
    exp_flags = 3;
    read_flags();
    base = intr_rises;
    repeat (20) @(posedge pclk);
    check("no new interrupt", base, intr_rises);
    $display("test power up finished");

    apb(1'b1, OFF_ADVERT, 32'hffff_ffff);
    apb(1'b0, OFF_ADVERT, 32'h0);
    check("advert", 32'(STEP) << STEPPED_BIT, rdata);
    apb(1'b0, 12'h0fc, 32'h0);
    check("unmapped error", 1, rerr);
    check("unmapped data", 0, rdata);
    $display("test registers finished");

    apb(1'b1, OFF_DEINIT, 32'h0000_007f);
    repeat (30) apb(1'b0, OFF_STATE, 32'h0);
    check("one lane short", 4, rdata[2:0]);
    apb(1'b1, OFF_DEINIT, 32'h0000_00ff);
    path_q = '{5, 6, 0};
    foreach (path_q[k])
      wait_state(path_q[k], 2);
    check("path released", 3'b001, power_out);
    exp_flags = 1;
    read_flags();
    $display("test deinit finished");

    apb(1'b1, OFF_CTRL, 32'h0000_0001);
    wait_state(0, 3);
    check("high power", 0, power_out.high_power);
    wait_state(0, 0);
    exp_flags = 2;
    read_flags();
    // with the pin released the allow bit alone must not hold low power
    lp_pin <= 1'b0;
    wait_state(0, 2);
    exp_flags = 2;
    read_flags();
    lp_pin <= 1'b1;
    wait_state(0, 0);
    exp_flags = 2;
    read_flags();
    $display("test low power finished");

    stg = 8'($urandom);
    apb(1'b1, OFF_STAGED, {24'h0, stg});
    apb(1'b1, OFF_CFG, 32'h0000_0001);
    apb(1'b0, OFF_CFG, 32'h0);
    check("config busy", 8'h81, rdata[7:0]);
    apb(1'b1, OFF_STAGED, {24'h0, ~stg});
    apb(1'b1, OFF_CFG, 32'h0000_0001);
    repeat (95) @(posedge pclk);
    apb(1'b0, OFF_CFG, 32'h0);
    check("config done", 8'h14, rdata[7:0]);
    apb(1'b0, OFF_ACTIVE, 32'h0);
    check("active", {24'h0, ~stg}, rdata);
    apb(1'b1, OFF_CFG, 32'h0000_0004);
    apb(1'b0, OFF_CFG, 32'h0);
    check("pending cleared", 8'h10, rdata[7:0]);
    $display("test apply finished");

    apb(1'b1, OFF_CTRL, 32'h0);
    wait_state(0, 2);
    exp_flags = 2;
    read_flags();
    // high power first, then the path comes back
    apb(1'b1, OFF_DEINIT, 32'h0);
    wait_state(1, 2);
    apb(1'b1, OFF_STAGED, {24'h0, stg});
    apb(1'b1, OFF_CFG, 32'h0000_0001);
    apb(1'b0, OFF_CFG, 32'h0);
    check("apply in transient", 8'h10, rdata[7:0]);
    apb(1'b0, OFF_ACTIVE, 32'h0);
    check("active kept", {24'h0, ~stg}, rdata);
    wait_state(4, 2);
    exp_flags = 1;
    read_flags();
    // default mode takes an immediate apply in a steady path state
    apb(1'b1, OFF_CFG, 32'h0000_0002);
    apb(1'b0, OFF_ACTIVE, 32'h0);
    check("active immediate", {24'h0, stg}, rdata);
    $display("test transient apply finished");
    end_of_test();
  end
endmodule

`default_nettype wire
